// ===== bmx_matrix.sv
// six by six multi-layer crossbar, masters and slaves AHB-lite style
// assumes slaves take their HREADY from their own HREADYOUT, single clock
`timescale 1ns/1ps
`default_nettype none
`include "bmx_params.svh"
module bmx_matrix
   import bmx_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // master ports, index as fixed by the master numbering
   input wire logic [`BMX_NM-1:0][1:0] M_HTRANS,
   input wire logic [`BMX_NM-1:0][`BMX_AW-1:0] M_HADDR,
   input wire logic [`BMX_NM-1:0] M_HWRITE,
   input wire logic [`BMX_NM-1:0][2:0] M_HSIZE,
   input wire logic [`BMX_NM-1:0][2:0] M_HBURST,
   input wire logic [`BMX_NM-1:0][`BMX_DW-1:0] M_HWDATA,
   output logic [`BMX_NM-1:0][`BMX_DW-1:0] M_HRDATA,
   output logic [`BMX_NM-1:0] M_HREADY,
   output logic [`BMX_NM-1:0] M_HRESP,
   // slave ports, index as fixed by the slave numbering
   output logic [`BMX_NS-1:0] S_HSEL,
   output logic [`BMX_NS-1:0][1:0] S_HTRANS,
   output logic [`BMX_NS-1:0][`BMX_AW-1:0] S_HADDR,
   output logic [`BMX_NS-1:0] S_HWRITE,
   output logic [`BMX_NS-1:0][2:0] S_HSIZE,
   output logic [`BMX_NS-1:0][2:0] S_HBURST,
   output logic [`BMX_NS-1:0][`BMX_DW-1:0] S_HWDATA,
   output logic [`BMX_NS-1:0][2:0] S_HMASTER,
   input wire logic [`BMX_NS-1:0][`BMX_DW-1:0] S_HRDATA,
   input wire logic [`BMX_NS-1:0] S_HREADYOUT,
   input wire logic [`BMX_NS-1:0] S_HRESP
);
   bmx_top_t st_r;
   bmx_top_t st_nxt;

   logic [`BMX_NM-1:0] hit;
   bmx_idx_t [`BMX_NM-1:0] sidx;
   bmx_idx_t [`BMX_NS-1:0] gnt;
   logic [`BMX_NM-1:0] active;
   logic [`BMX_NM-1:0] pr;
   logic [`BMX_NM-1:0] acc;
   logic [`BMX_NS-1:0][`BMX_NM-1:0] req_ms;
   logic [`BMX_NS-1:0][`BMX_NM-1:0] hold_ms;
   logic [`BMX_NM-1:0][`BMX_DW-1:0] rd;
   logic [`BMX_NM-1:0] rs;
   logic [`BMX_NS-1:0] take;

   // one decoder per master, one arbiter per slave
   genvar gi;
   generate
      for (gi = 0; gi < `BMX_NM; gi++) begin : g_dec
         bmx_decoder #(
            .MIDX(bmx_idx_t'(gi))
         ) u_dec (
            .addr(M_HADDR[gi]),
            .hit(hit[gi]),
            .sidx(sidx[gi])
         );
      end
      for (gi = 0; gi < `BMX_NS; gi++) begin : g_arb
         bmx_arb_if arb_i ();
         assign arb_i.req = req_ms[gi];
         assign arb_i.hold = hold_ms[gi];
         assign arb_i.ready = S_HREADYOUT[gi];
         assign gnt[gi] = arb_i.grant;
         bmx_arbiter u_arb (
            .clk(CORE_CLK),
            .rst_n(RESET_N),
            .arb(arb_i)
         );
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      active = '0;
      pr = '0;
      acc = '0;
      req_ms = '0;
      hold_ms = '0;
      rd = '0;
      rs = '0;
      take = '0;
      S_HSEL = '0;
      S_HTRANS = '0;
      S_HADDR = '0;
      S_HWRITE = '0;
      S_HSIZE = '0;
      S_HBURST = '0;
      S_HWDATA = '0;
      S_HMASTER = '0;
      M_HRDATA = '0;
      M_HREADY = '0;
      M_HRESP = '0;

      // data phase state of each master decides if it may issue
      for (int m = 0; m < `BMX_NM; m++) begin
         case (st_r.mst[m].state)
            BMX_IDLE: begin
               pr[m] = 1'b1;
            end
            BMX_DATA: begin
               pr[m] = S_HREADYOUT[st_r.mst[m].slv];
               rd[m] = S_HRDATA[st_r.mst[m].slv];
               rs[m] = S_HRESP[st_r.mst[m].slv];
            end
            BMX_HOLD: begin
               pr[m] = 1'b1;
               rd[m] = st_r.mst[m].rdata;
               rs[m] = st_r.mst[m].resp;
            end
            BMX_ERR1: begin
               pr[m] = 1'b0;
               rs[m] = `BMX_RESP_ERR;
            end
            BMX_ERR2: begin
               pr[m] = 1'b1;
               rs[m] = `BMX_RESP_ERR;
            end
            default: begin
               pr[m] = 1'b0;
            end
         endcase
         active[m] = (M_HTRANS[m] == `BMX_TR_NSEQ) ||
                     (M_HTRANS[m] == `BMX_TR_SEQ);
         for (int s = 0; s < `BMX_NS; s++) begin
            // unwired or unmapped requests never reach a slave
            req_ms[s][m] = active[m] & hit[m] & pr[m] &
                           (sidx[m] == bmx_idx_t'(s));
            // keep the grant through a burst
            hold_ms[s][m] = hit[m] & (sidx[m] == bmx_idx_t'(s)) &
               ((M_HTRANS[m] == `BMX_TR_SEQ) ||
                (M_HTRANS[m] == `BMX_TR_BUSY) ||
                (active[m] && M_HBURST[m] != `BMX_BURST_SINGLE));
         end
      end

      // each slave follows its own granted master
      for (int s = 0; s < `BMX_NS; s++) begin
         S_HSEL[s] = req_ms[s][gnt[s]];
         S_HTRANS[s] = S_HSEL[s] ? M_HTRANS[gnt[s]] : `BMX_TR_IDLE;
         S_HADDR[s] = M_HADDR[gnt[s]];
         S_HWRITE[s] = M_HWRITE[gnt[s]];
         S_HSIZE[s] = M_HSIZE[gnt[s]];
         S_HBURST[s] = M_HBURST[gnt[s]];
         S_HMASTER[s] = gnt[s];
         take[s] = S_HSEL[s] & S_HREADYOUT[s];
         acc[gnt[s]] = acc[gnt[s]] | take[s];
         if (st_r.own[s].vld) begin
            S_HWDATA[s] = M_HWDATA[st_r.own[s].mst];
         end
         if (S_HREADYOUT[s]) begin
            st_nxt.own[s].vld = take[s];
            st_nxt.own[s].mst = gnt[s];
         end
      end

      // answer each master and advance its data phase
      for (int m = 0; m < `BMX_NM; m++) begin
         M_HREADY[m] = pr[m] & (!active[m] | !hit[m] | acc[m]);
         M_HRDATA[m] = rd[m];
         M_HRESP[m] = rs[m];
         if (M_HREADY[m]) begin
            if (active[m] && !hit[m]) begin
               st_nxt.mst[m].state = BMX_ERR1;
            end else if (acc[m]) begin
               st_nxt.mst[m].state = BMX_DATA;
               st_nxt.mst[m].slv = sidx[m];
            end else begin
               st_nxt.mst[m].state = BMX_IDLE;
            end
         end else if (st_r.mst[m].state == BMX_ERR1) begin
            st_nxt.mst[m].state = BMX_ERR2;
         end else if (pr[m] && st_r.mst[m].state != BMX_IDLE) begin
            // slave finished but next address still waits for a grant
            st_nxt.mst[m].state = BMX_HOLD;
            st_nxt.mst[m].rdata = rd[m];
            st_nxt.mst[m].resp = rs[m];
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r <= '0;
         for (int m = 0; m < `BMX_NM; m++) begin
            st_r.mst[m].state <= BMX_IDLE;
         end
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== bmx_params.svh
// constants of the six by six bus matrix: sizes, address map, path table
// assumes AHB-lite style masters and slaves on one clock
`ifndef BMX_PARAMS_SVH
`define BMX_PARAMS_SVH

`define BMX_NM 6
`define BMX_NS 6
`define BMX_AW 32
`define BMX_DW 32

// master indices
`define BMX_M_GDMA 3'h0
`define BMX_M_UDMA 3'h1
`define BMX_M_DDMA 3'h2
`define BMX_M_PDMA 3'h3
`define BMX_M_PIF 3'h4
`define BMX_M_PDF 3'h5

// slave indices
`define BMX_S_ROM 3'h0
`define BMX_S_SRAM 3'h1
`define BMX_S_DREG 3'h2
`define BMX_S_UREG 3'h3
`define BMX_S_EXT 3'h4
`define BMX_S_BRG 3'h5

// bank field and 1 MB area field inside bank 0
`define BMX_BANK_HI 31
`define BMX_BANK_LO 28
`define BMX_AREA_HI 27
`define BMX_AREA_LO 20
`define BMX_BANK_INT 4'h0
`define BMX_BANK_EXT_LO 4'h1
`define BMX_BANK_EXT_HI 4'h8
`define BMX_BANK_BRG 4'hF
`define BMX_AREA_BOOT 8'h00
`define BMX_AREA_SRAM_LO 8'h01
`define BMX_AREA_SRAM_HI 8'h03
`define BMX_AREA_ROM 8'h04
`define BMX_AREA_DREG 8'h05
`define BMX_AREA_UREG 8'h06

// allowed masters per slave, bit n set means master n is wired
`define BMX_PATH_ROM 6'h3B
`define BMX_PATH_SRAM 6'h3F
`define BMX_PATH_DREG 6'h30
`define BMX_PATH_UREG 6'h30
`define BMX_PATH_EXT 6'h3F
`define BMX_PATH_BRG 6'h07

// transfer codes
`define BMX_TR_IDLE 2'h0
`define BMX_TR_BUSY 2'h1
`define BMX_TR_NSEQ 2'h2
`define BMX_TR_SEQ 2'h3
`define BMX_BURST_SINGLE 3'h0
`define BMX_RESP_OKAY 1'h0
`define BMX_RESP_ERR 1'h1

`endif

// ===== bmx_pkg.sv
// types shared by the bus matrix modules
// assumes bmx_params.svh sits in the same folder
`default_nettype none
`include "bmx_params.svh"
package bmx_pkg;
   typedef logic [2:0] bmx_idx_t;

   // data phase of one master port
   typedef enum logic [4:0] {
      BMX_IDLE = 5'h01,
      BMX_DATA = 5'h02,
      BMX_HOLD = 5'h04,
      BMX_ERR1 = 5'h08,
      BMX_ERR2 = 5'h10
   } bmx_dph_t;

   typedef struct packed {
      bmx_dph_t state;
      bmx_idx_t slv;
      logic [`BMX_DW-1:0] rdata;
      logic resp;
   } bmx_mst_t;

   typedef struct packed {
      logic vld;
      bmx_idx_t mst;
   } bmx_own_t;

   typedef struct packed {
      bmx_mst_t [`BMX_NM-1:0] mst;
      bmx_own_t [`BMX_NS-1:0] own;
   } bmx_top_t;

   typedef struct packed {
      bmx_idx_t grant;
   } bmx_arb_t;
endpackage
`default_nettype wire

// ===== bmx_arb_if.sv
// request and grant bundle between the matrix core and one slave arbiter
// assumes the package has been compiled first
`timescale 1ns/1ps
`default_nettype none
`include "bmx_params.svh"
interface bmx_arb_if;
   import bmx_pkg::*;
   logic [`BMX_NM-1:0] req;
   logic [`BMX_NM-1:0] hold;
   logic ready;
   bmx_idx_t grant;
   modport arb (input req, input hold, input ready, output grant);
   modport mst (output req, output hold, output ready, input grant);
endinterface
`default_nettype wire

// ===== bmx_decoder.sv
// address decoder of one master port, same map for every instance
// assumes the address is the master's current address phase
`timescale 1ns/1ps
`default_nettype none
`include "bmx_params.svh"
module bmx_decoder
   import bmx_pkg::*;
#(
   parameter bmx_idx_t MIDX = `BMX_M_GDMA
) (
   // address phase
   input wire logic [`BMX_AW-1:0] addr,
   // decode result
   output logic hit,
   output bmx_idx_t sidx
);
   logic found;
   logic [`BMX_NM-1:0] mask;
   logic [3:0] bank;
   logic [7:0] area;

   always_comb begin
      bank = addr[`BMX_BANK_HI:`BMX_BANK_LO];
      area = addr[`BMX_AREA_HI:`BMX_AREA_LO];
      found = 1'b1;
      sidx = `BMX_S_ROM;
      if (bank == `BMX_BANK_INT) begin
         if (area == `BMX_AREA_BOOT || area == `BMX_AREA_ROM) begin
            sidx = `BMX_S_ROM;
         end else if (area >= `BMX_AREA_SRAM_LO &&
                      area <= `BMX_AREA_SRAM_HI) begin
            sidx = `BMX_S_SRAM;
         end else if (area == `BMX_AREA_DREG) begin
            sidx = `BMX_S_DREG;
         end else if (area == `BMX_AREA_UREG) begin
            sidx = `BMX_S_UREG;
         end else begin
            found = 1'b0;
         end
      end else if (bank >= `BMX_BANK_EXT_LO &&
                   bank <= `BMX_BANK_EXT_HI) begin
         sidx = `BMX_S_EXT;
      end else if (bank == `BMX_BANK_BRG) begin
         sidx = `BMX_S_BRG;
      end else begin
         found = 1'b0;
      end
      case (sidx)
         `BMX_S_ROM: mask = `BMX_PATH_ROM;
         `BMX_S_SRAM: mask = `BMX_PATH_SRAM;
         `BMX_S_DREG: mask = `BMX_PATH_DREG;
         `BMX_S_UREG: mask = `BMX_PATH_UREG;
         `BMX_S_EXT: mask = `BMX_PATH_EXT;
         `BMX_S_BRG: mask = `BMX_PATH_BRG;
         default: mask = '0;
      endcase
      hit = found & mask[MIDX];
   end
endmodule
`default_nettype wire

// ===== bmx_arbiter.sv
// round robin arbiter of one slave port
// assumes req and hold come from the matrix core on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "bmx_params.svh"
module bmx_arbiter
   import bmx_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request and grant
   bmx_arb_if.arb arb
);
   bmx_arb_t st_r;
   bmx_arb_t st_nxt;
   logic found;
   int cand;

   assign arb.grant = st_r.grant;

   always_comb begin
      st_nxt = st_r;
      found = 1'b0;
      cand = 0;
      // move only when the slave is ready and no burst is under way
      if (arb.ready && !arb.hold[st_r.grant]) begin
         for (int i = 1; i <= `BMX_NM; i++) begin
            cand = (int'(st_r.grant) + i) % `BMX_NM;
            if (!found && arb.req[cand]) begin
               found = 1'b1;
               st_nxt.grant = bmx_idx_t'(cand);
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule
`default_nettype wire

// ===== bmx_chk.sv
// port checker of the six by six bus matrix
// assumes bmx_pkg is compiled first and one clock domain
`timescale 1ns/1ps
`default_nettype none
module bmx_chk (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // master side
   input wire logic [5:0][1:0] M_HTRANS,
   input wire logic [5:0][31:0] M_HADDR,
   input wire logic [5:0][31:0] M_HWDATA,
   input wire logic [5:0] M_HWRITE,
   input wire logic [5:0][2:0] M_HBURST,
   input wire logic [5:0] M_HREADY,
   input wire logic [5:0] M_HRESP,
   // slave side
   input wire logic [5:0] S_HSEL,
   input wire logic [5:0][1:0] S_HTRANS,
   input wire logic [5:0][2:0] S_HBURST,
   input wire logic [5:0][31:0] S_HADDR,
   input wire logic [5:0] S_HWRITE,
   input wire logic [5:0][31:0] S_HWDATA,
   input wire logic [5:0][2:0] S_HMASTER,
   input wire logic [5:0] S_HREADYOUT
);
   localparam logic [5:0] PATH [0:5] = '{6'h3B, 6'h3F, 6'h30, 6'h30,
                                          6'h3F, 6'h07};
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);
   // slave index of an address, 7 when unmapped
   function automatic logic [2:0] dec(logic [31:0] a);
      case (a[31:28])
         4'h0: case (a[27:20])
            8'h00, 8'h04: dec = 3'h0;
            8'h01, 8'h02, 8'h03: dec = 3'h1;
            8'h05: dec = 3'h2;
            8'h06: dec = 3'h3;
            default: dec = 3'h7;
         endcase
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: dec = 3'h4;
         4'hF: dec = 3'h5;
         default: dec = 3'h7;
      endcase
   endfunction
   function automatic logic bad(logic [31:0] a, int m);
      logic [2:0] s;
      s = dec(a);
      bad = (s == 3'h7) || !PATH[s][m];
   endfunction
   for (genvar i = 0; i < 6; i++) begin : g
      grant_hold_a: assert property ($changed(S_HMASTER[i]) |->
         $past(S_HREADYOUT[i])) else $error("grant moved mid transfer");
      path_ok_a: assert property (S_HSEL[i] |->
         PATH[i][S_HMASTER[i]]) else $error("unwired path selected");
      slave_map_a: assert property (S_HSEL[i] |->
         dec(S_HADDR[i]) == 3'(i)) else $error("slave selected off map");
      addr_pass_a: assert property (S_HSEL[i] |->
         S_HADDR[i] == M_HADDR[S_HMASTER[i]] && M_HTRANS[S_HMASTER[i]][1])
         else $error("slave address not from owner");
      ctrl_pass_a: assert property (S_HSEL[i] |->
         S_HTRANS[i] == M_HTRANS[S_HMASTER[i]] &&
         S_HWRITE[i] == M_HWRITE[S_HMASTER[i]] &&
         S_HBURST[i] == M_HBURST[S_HMASTER[i]])
         else $error("slave control not from owner");
      burst_hold_a: assert property (S_HSEL[i] &&
         M_HBURST[S_HMASTER[i]] != 3'h0 |=> $stable(S_HMASTER[i]))
         else $error("grant moved inside burst");
      wdata_route_a: assert property (S_HSEL[i] && S_HREADYOUT[i] &&
         S_HWRITE[i] |=> S_HWDATA[i] == M_HWDATA[$past(S_HMASTER[i])])
         else $error("write data from wrong master");
      unmapped_err_a: assert property (M_HTRANS[i][1] && M_HREADY[i] &&
         bad(M_HADDR[i], i) |=> !M_HREADY[i] && M_HRESP[i])
         else $error("bad address not refused");
      err_first_a: assert property ($rose(M_HRESP[i]) |->
         !M_HREADY[i]) else $error("error without first cycle");
      err_end_a: assert property (M_HRESP[i] && M_HREADY[i] |->
         $past(M_HRESP[i]) && !$past(M_HREADY[i]))
         else $error("error ended in one cycle");
   end
endmodule
bind bmx_matrix bmx_chk u_chk (.*);
`default_nettype wire

// ===== bmx_slv_model.sv
// behavioural slaves on the six slave ports, always OKAY
// assumes each slave uses its own ready as HREADY
`timescale 1ns/1ps
`default_nettype none
module bmx_slv_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // slave ports
   input wire logic [5:0] sel,
   input wire logic [5:0][1:0] trans,
   input wire logic [5:0][31:0] addr,
   input wire logic [5:0] write,
   input wire logic [5:0][2:0] size,
   input wire logic [5:0][31:0] wdata,
   output logic [5:0][31:0] rdata,
   output logic [5:0] ready,
   output logic [5:0] resp,
   // wait states and record
   input wire logic [5:0][1:0] wait_n,
   output logic [5:0][7:0] hits,
   output logic [5:0][31:0] last_wd,
   output logic [5:0][2:0] last_sz
);
   logic [5:0] busy;
   logic [5:0] wr;
   logic [5:0][1:0] cnt;
   logic [5:0][31:0] ad;
   for (genvar s = 0; s < 6; s++) begin : g
      logic [31:0] val;
      assign val = {ad[s][31:4], 1'b0, 3'(s)};
      assign ready[s] = !busy[s] || cnt[s] == 2'h0;
      // read data only while valid, inverted otherwise
      assign rdata[s] = (busy[s] && !wr[s] && ready[s]) ? val : ~val;
      assign resp[s] = 1'b0;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= '0;
         wr <= '0;
         cnt <= '0;
         ad <= '0;
         hits <= '0;
         last_wd <= '0;
         last_sz <= '0;
      end else begin
         for (int s = 0; s < 6; s++) begin
            if (busy[s] && ready[s]) begin
               busy[s] <= 1'b0;
               if (wr[s]) last_wd[s] <= wdata[s];
            end else if (busy[s]) begin
               cnt[s] <= cnt[s] - 2'h1;
            end
            if (sel[s] && trans[s][1] && ready[s]) begin
               busy[s] <= 1'b1;
               cnt[s] <= wait_n[s];
               ad[s] <= addr[s];
               wr[s] <= write[s];
               last_sz[s] <= size[s];
               hits[s] <= hits[s] + 8'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench of the six by six bus matrix
// assumes the checker binds itself and the slave model answers OKAY
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0][1:0] m_tr = '0;
   logic [5:0][31:0] m_ad = '0;
   logic [5:0][31:0] m_wd = '0;
   logic [5:0] m_wr = '0;
   logic [5:0][2:0] m_sz = '0;
   logic [5:0][2:0] m_bu = '0;
   logic [5:0][1:0] wt = '0;
   logic [5:0][31:0] m_rd, s_ad, s_wd, s_rd, lwd;
   logic [5:0] m_rdy, m_rs, s_sel, s_wr, s_rdy, s_rs;
   logic [5:0][1:0] s_tr;
   logic [5:0][2:0] s_sz, s_bu, s_ms, lsz;
   logic [5:0][7:0] hits;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   localparam logic [5:0] PATHS [0:5] = '{6'h3B, 6'h3F, 6'h30, 6'h30,
                                           6'h3F, 6'h07};
   localparam logic [31:0] SADR [0:5] = '{32'h0040_0010, 32'h0010_0020,
      32'h0050_0030, 32'h0060_0040, 32'h1000_0050, 32'hF000_0060};
   always #10 clk = ~clk;
   bmx_matrix dut (.CORE_CLK(clk), .RESET_N(rst_n), .M_HTRANS(m_tr),
      .M_HADDR(m_ad), .M_HWRITE(m_wr), .M_HSIZE(m_sz), .M_HBURST(m_bu),
      .M_HWDATA(m_wd), .M_HRDATA(m_rd), .M_HREADY(m_rdy), .M_HRESP(m_rs),
      .S_HSEL(s_sel), .S_HTRANS(s_tr), .S_HADDR(s_ad), .S_HWRITE(s_wr),
      .S_HSIZE(s_sz), .S_HBURST(s_bu), .S_HWDATA(s_wd), .S_HMASTER(s_ms),
      .S_HRDATA(s_rd), .S_HREADYOUT(s_rdy), .S_HRESP(s_rs));
   bmx_slv_model u_slv (.clk(clk), .rst_n(rst_n), .sel(s_sel),
      .trans(s_tr), .addr(s_ad), .write(s_wr), .size(s_sz), .wdata(s_wd),
      .rdata(s_rd), .ready(s_rdy), .resp(s_rs), .wait_n(wt),
      .hits(hits), .last_wd(lwd), .last_sz(lsz));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one single transfer, address phase then data phase
   task automatic xfer(input int m, input logic [31:0] a, input logic w,
      input logic [2:0] sz, input logic [31:0] wd, output logic [31:0] rd,
      output logic rs, output int n);
      logic r;
      n = 0;
      @(posedge clk);
      m_tr[m] <= 2'h2;
      m_ad[m] <= a;
      m_wr[m] <= w;
      m_sz[m] <= sz;
      do begin
         @(negedge clk);
         r = m_rdy[m];
         @(posedge clk);
         n++;
      end while (!r && n < 40);
      if (!r) n_fail++;
      m_tr[m] <= 2'h0;
      m_wd[m] <= wd;
      do begin
         @(negedge clk);
         r = m_rdy[m];
         rd = m_rd[m];
         rs = m_rs[m];
         @(posedge clk);
         n++;
      end while (!r && n < 80);
      if (!r) n_fail++;
   endtask
   task automatic t_paths();
      logic [31:0] rd;
      logic rs;
      int n;
      logic [7:0] h;
      for (int m = 0; m < 6; m++) begin
         for (int s = 0; s < 6; s++) begin
            h = hits[s];
            xfer(m, SADR[s], 1'b0, 3'h2, 32'h0, rd, rs, n);
            chk(32'(rs), 32'(!PATHS[s][m]));
            chk(32'(hits[s] - h), 32'(PATHS[s][m]));
            if (PATHS[s][m]) chk(rd, {SADR[s][31:4], 1'b0, 3'(s)});
         end
      end
   endtask
   task automatic t_map();
      logic [31:0] a [0:7] = '{32'h0000_0000, 32'h0030_0000,
         32'h0070_0000, 32'h1000_0000, 32'h8FFF_FFFC, 32'h9000_0000,
         32'hE000_0000, 32'hF000_0000};
      logic [2:0] e [0:7] = '{3'h0, 3'h1, 3'h7, 3'h4, 3'h4, 3'h7, 3'h7,
                              3'h5};
      logic [31:0] rd;
      logic rs;
      int n;
      for (int i = 0; i < 8; i++) begin
         xfer(i % 2, a[i], 1'b0, 3'h2, 32'h0, rd, rs, n);
         chk(32'(rs), 32'(e[i] == 3'h7));
         if (e[i] != 3'h7) chk(rd, {a[i][31:4], 1'b0, e[i]});
      end
   endtask
   task automatic t_size();
      logic [31:0] rd;
      logic rs;
      int n;
      for (int z = 0; z < 3; z++) begin
         xfer(5, 32'h0020_0000, 1'b1, 3'(z), 32'hA5C3_0F00 + z, rd, rs, n);
         @(negedge clk);
         chk(lwd[1], 32'hA5C3_0F00 + z);
         chk(32'(lsz[1]), z);
      end
   endtask
   task automatic t_conc();
      logic [31:0] rd [0:3];
      logic rs [0:3];
      int n [0:3];
      int sl [0:3] = '{5, 4, 0, 1};
      fork
         xfer(0, SADR[5], 1'b0, 3'h2, 32'h0, rd[0], rs[0], n[0]);
         xfer(1, SADR[4], 1'b0, 3'h2, 32'h0, rd[1], rs[1], n[1]);
         xfer(4, SADR[0], 1'b0, 3'h2, 32'h0, rd[2], rs[2], n[2]);
         xfer(5, SADR[1], 1'b0, 3'h2, 32'h0, rd[3], rs[3], n[3]);
      join
      for (int i = 0; i < 4; i++) begin
         chk(rd[i], {SADR[sl[i]][31:4], 1'b0, 3'(sl[i])});
         chk(32'(n[i] < 5), 32'h1);
      end
   endtask
   task automatic t_cont();
      logic [31:0] rd [0:2];
      logic rs [0:2];
      int n [0:2];
      wt[1] <= 2'h2;
      fork
         xfer(0, 32'h0010_0100, 1'b0, 3'h2, 32'h0, rd[0], rs[0], n[0]);
         xfer(1, 32'h0010_0200, 1'b0, 3'h2, 32'h0, rd[1], rs[1], n[1]);
         xfer(3, 32'h0010_0300, 1'b0, 3'h2, 32'h0, rd[2], rs[2], n[2]);
      join
      for (int i = 0; i < 3; i++) begin
         chk(rd[i], 32'h0010_0001 | (32'(i + 1) << 8));
      end
      chk(32'(n[0] != n[1] && n[1] != n[2] && n[0] != n[2]), 32'h1);
      wt[1] <= 2'h0;
   endtask
   // master 2 owns the SRAM grant, then races master 3, single then burst
   task automatic t_burst();
      logic [31:0] rd [0:1];
      logic rs [0:1];
      int n [0:3];
      for (int b = 0; b < 2; b++) begin
         m_bu[2] <= 3'(b);
         xfer(2, 32'h0010_0400, 1'b0, 3'h2, 32'h0, rd[0], rs[0], n[0]);
         fork
            xfer(2, 32'h0010_0400, 1'b0, 3'h2, 32'h0, rd[0], rs[0], n[0]);
            xfer(3, 32'h0010_0500, 1'b0, 3'h2, 32'h0, rd[1], rs[1],
               n[2 + b]);
         join
         chk(rd[0], 32'h0010_0401);
         chk(rd[1], 32'h0010_0501);
      end
      m_bu[2] <= 3'h0;
      chk(n[3], n[2] + 1);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         complete_run();
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_paths();
      t_map();
      t_size();
      t_conc();
      t_cont();
      t_burst();
      complete_run();
   end
endmodule
`default_nettype wire
